// [rtl/backlight_diag_status_regs.sv]
`timescale 1ns/1ps
`include "diag_params.svh"

module backlight_diag_status_regs import diag_pkg::*;
(
    input wire logic sys_clk, // system clock, 20 MHz
    input wire logic rst, // sync reset, high
    input wire logic [7:0] reg_addr, // register offset
    input wire logic reg_rd, // read strobe
    input wire logic reg_wr, // write strobe, acked but stores nothing
    output logic [15:0] reg_rdata, // read data
    output logic reg_ack, // access done pulse
    input wire logic [15:0] input_duty_live, // measured input duty
    input wire logic [15:0] output_duty_live, // applied output duty
    input wire logic [11:0] sink_current_dac_code, // sink DAC code
    input wire logic [10:0] boost_voltage_code_field, // boost code
    input wire logic strap_sample, // start-up sample pulse
    input wire logic [2:0] dim_freq_strap, // frequency strap code
    input wire logic [2:0] string_layout_strap, // layout strap code
    input wire logic [2:0] switch_frequency_strap, // boost freq strap
    input wire logic [2:0] mode_strap, // mode/address strap code
    output logic strap_detect_done // detection captured
);

    access_type state_reg;
    access_type state_next;
    logic [`REG_WIDTH-1:0] strap_word;
    logic [`REG_WIDTH-1:0] read_word;

    strap_if straps();

    strap_capture capture_unit
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .strap_sample(strap_sample),
        .dim_freq_strap(dim_freq_strap),
        .string_layout_strap(string_layout_strap),
        .switch_frequency_strap(switch_frequency_strap),
        .mode_strap(mode_strap),
        .result(straps.capture)
    );

    // ***************************************************************
    // detection word
    // ***************************************************************
    always_comb
    begin
        strap_word = `RESET_DATA;
        strap_word[`RESERVED_ONE_BIT] = 1'b1;
        strap_word[`DIM_FREQ_LSB +: `STRAP_CODE_WIDTH] =
            straps.detected_dim_frequency;
        strap_word[`LAYOUT_LSB +: `STRAP_CODE_WIDTH] =
            straps.detected_string_layout;
        strap_word[`SWITCH_FREQ_LSB +: `STRAP_CODE_WIDTH] =
            straps.detected_switch_frequency;
        strap_word[`MODE_LSB +: `STRAP_CODE_WIDTH] =
            straps.dim_mode_select;
    end

    // ***************************************************************
    // read decode
    // ***************************************************************
    always_comb
    begin
        read_word = `RESET_DATA;
        case (reg_addr)
            `OFS_INPUT_DUTY:
            begin
                read_word = input_duty_live;
            end
            `OFS_OUTPUT_DUTY:
            begin
                read_word = output_duty_live;
            end
            `OFS_SINK_CURRENT:
            begin
                read_word[`SINK_CODE_WIDTH-1:0] = sink_current_dac_code;
            end
            `OFS_BOOST_CODE:
            begin
                read_word[`BOOST_CODE_WIDTH-1:0] = boost_voltage_code_field;
            end
            `OFS_STRAP_RESULT:
            begin
                read_word = strap_word;
            end
            default:
            begin
                read_word = `RESET_DATA;
            end
        endcase
    end

    // ***************************************************************
    // access register
    // ***************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = reg_rd | reg_wr;
        if (reg_rd)
        begin
            state_next.rdata = read_word;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign reg_ack = state_reg.ack;
    assign strap_detect_done = straps.detect_done;

endmodule

// [rtl/diag_params.svh]
// Behaviour
// - measured input duty readable at 16h
// - applied output duty readable at 18h
// - 12-bit sink DAC code at 1Ah
// - 11-bit boost code at 1Ch
// - boost code steps output voltage linearly
// - detected dim frequency at 1Eh bits 14-12
// - detected string layout at bits 10-8
// - detected switch frequency at bits 5-3
// - bits 15,7-6 zero; bit 11 one
// - dimming mode and address in bits 2-0
`ifndef DIAG_PARAMS_SVH
`define DIAG_PARAMS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define OFS_INPUT_DUTY 8'h16
`define OFS_OUTPUT_DUTY 8'h18
`define OFS_SINK_CURRENT 8'h1A
`define OFS_BOOST_CODE 8'h1C
`define OFS_STRAP_RESULT 8'h1E

// ***************************************************************
// field layout
// ***************************************************************
`define REG_WIDTH 16
`define SINK_CODE_WIDTH 12
`define BOOST_CODE_WIDTH 11
`define STRAP_CODE_WIDTH 3
`define DIM_FREQ_LSB 12
`define RESERVED_ONE_BIT 11
`define LAYOUT_LSB 8
`define SWITCH_FREQ_LSB 3
`define MODE_LSB 0

// ***************************************************************
// reset values
// ***************************************************************
`define RESET_DATA 16'h0000
`define RESET_CODE 3'h0

`endif

// [rtl/diag_pkg.sv]
`include "diag_params.svh"

package diag_pkg;

    typedef logic [`STRAP_CODE_WIDTH-1:0] strap_code_type;

    typedef enum logic [1:0]
    {
        CAP_WAIT = 2'b00,
        CAP_HELD = 2'b01
    } capture_state_type;

    typedef struct packed
    {
        strap_code_type dim_freq_meta;
        strap_code_type layout_meta;
        strap_code_type switch_meta;
        strap_code_type mode_meta;
        strap_code_type dim_freq_sync;
        strap_code_type layout_sync;
        strap_code_type switch_sync;
        strap_code_type mode_sync;
        strap_code_type dim_freq_held;
        strap_code_type layout_held;
        strap_code_type switch_held;
        strap_code_type mode_held;
        capture_state_type phase;
    } capture_type;

    typedef struct packed
    {
        logic [`REG_WIDTH-1:0] rdata;
        logic ack;
    } access_type;

endpackage

// [rtl/strap_if.sv]
`timescale 1ns/1ps

interface strap_if;
    import diag_pkg::*;

    strap_code_type detected_dim_frequency;
    strap_code_type detected_string_layout;
    strap_code_type detected_switch_frequency;
    strap_code_type dim_mode_select;
    logic detect_done;

    modport capture
    (
        output detected_dim_frequency,
        output detected_string_layout,
        output detected_switch_frequency,
        output dim_mode_select,
        output detect_done
    );

    modport reader
    (
        input detected_dim_frequency,
        input detected_string_layout,
        input detected_switch_frequency,
        input dim_mode_select,
        input detect_done
    );
endinterface

// [rtl/strap_capture.sv]
`timescale 1ns/1ps
`include "diag_params.svh"

module strap_capture import diag_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // sync reset, high
    input wire logic strap_sample, // start-up sample pulse
    input wire logic [2:0] dim_freq_strap, // frequency strap code
    input wire logic [2:0] string_layout_strap, // layout strap code
    input wire logic [2:0] switch_frequency_strap, // boost freq strap code
    input wire logic [2:0] mode_strap, // mode/address strap code
    strap_if.capture result // held detection results
);

    capture_type state_reg;
    capture_type state_next;

    // ***************************************************************
    // synchronise and capture
    // ***************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.dim_freq_meta = dim_freq_strap;
        state_next.layout_meta = string_layout_strap;
        state_next.switch_meta = switch_frequency_strap;
        state_next.mode_meta = mode_strap;
        state_next.dim_freq_sync = state_reg.dim_freq_meta;
        state_next.layout_sync = state_reg.layout_meta;
        state_next.switch_sync = state_reg.switch_meta;
        state_next.mode_sync = state_reg.mode_meta;
        case (state_reg.phase)
            CAP_WAIT:
            begin
                if (strap_sample)
                begin
                    state_next.dim_freq_held = state_reg.dim_freq_sync;
                    state_next.layout_held = state_reg.layout_sync;
                    state_next.switch_held = state_reg.switch_sync;
                    state_next.mode_held = state_reg.mode_sync;
                    state_next.phase = CAP_HELD;
                end
            end
            CAP_HELD:
            begin
                state_next.phase = CAP_HELD;
            end
            default:
            begin
                state_next.phase = CAP_WAIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.phase <= CAP_WAIT;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign result.detected_dim_frequency = state_reg.dim_freq_held;
    assign result.detected_string_layout = state_reg.layout_held;
    assign result.detected_switch_frequency = state_reg.switch_held;
    assign result.dim_mode_select = state_reg.mode_held;
    assign result.detect_done = (state_reg.phase == CAP_HELD);

endmodule

// [test/diag_asserts.sv]
`timescale 1ns/1ps
// ****
// register port and strap capture checks
// ****
module diag_asserts
(
    input wire logic sys_clk, // clock
    input wire logic rst, // sync reset
    input wire logic [7:0] reg_addr, // offset
    input wire logic reg_rd, // read strobe
    input wire logic reg_wr, // write strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_ack, // done pulse
    input wire logic [15:0] input_duty_live, // input duty
    input wire logic [15:0] output_duty_live, // output duty
    input wire logic [11:0] sink_current_dac_code, // sink code
    input wire logic [10:0] boost_voltage_code_field, // boost code
    input wire logic strap_sample, // sample pulse
    input wire logic strap_detect_done // captured
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff rst;
    property p_ack; (reg_rd || reg_wr) |=> reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_noack; !(reg_rd || reg_wr) |=> !reg_ack; endproperty
    a_noack: assert property (p_noack) else $error("stray ack");
    property p_in; reg_rd && reg_addr == 8'h16
        |=> reg_rdata == $past(input_duty_live); endproperty
    a_in: assert property (p_in) else $error("input duty");
    property p_out; reg_rd && reg_addr == 8'h18
        |=> reg_rdata == $past(output_duty_live); endproperty
    a_out: assert property (p_out) else $error("output duty");
    property p_sink; reg_rd && reg_addr == 8'h1A
        |=> reg_rdata == {4'h0, $past(sink_current_dac_code)}; endproperty
    a_sink: assert property (p_sink) else $error("sink code");
    property p_boost; reg_rd && reg_addr == 8'h1C
        |=> reg_rdata == {5'h00, $past(boost_voltage_code_field)}; endproperty
    a_boost: assert property (p_boost) else $error("boost code");
    property p_resv; reg_rd && reg_addr == 8'h1E |=> reg_rdata[11]
        && !reg_rdata[15] && reg_rdata[7:6] == 2'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits");
    property p_wr; reg_wr && !reg_rd |=> $stable(reg_rdata); endproperty
    a_wr: assert property (p_wr) else $error("write changed data");
    property p_cap; strap_sample |=> strap_detect_done; endproperty
    a_cap: assert property (p_cap) else $error("capture late");
    property p_hold; strap_detect_done |=> strap_detect_done; endproperty
    a_hold: assert property (p_hold) else $error("done dropped");
endmodule

// [test/host_model.sv]
`timescale 1ns/1ps
// ****
// host reading and writing over the register port
// ****
module host_model
(
    output logic [7:0] reg_addr, // offset
    output logic reg_rd, // read strobe
    output logic reg_wr, // write strobe
    input wire logic sys_clk, // clock
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_ack // done pulse
);
    initial
    begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] a,
        output logic [15:0] d, output logic ok);
        int n;
        @(posedge sys_clk);
        #5;
        reg_addr = a;
        reg_rd = !wr;
        reg_wr = wr;
        @(posedge sys_clk);
        #5;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        // released offset shows no stale value
        reg_addr = ~a;
        ok = 1'b0;
        d = 16'h0000;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (reg_ack === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata;
            end
            else
            begin
                @(posedge sys_clk);
                #5;
            end
        end
    endtask
endmodule

// [test/backlight_diag_status_regs_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) \
    begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
// ****
// bench top
// ****
module backlight_diag_status_regs_tb;
    logic sys_clk = 1'b0, rst = 1'b1, reg_rd, reg_wr, reg_ack, ok;
    logic strap_sample = 1'b0, strap_detect_done;
    logic [7:0] reg_addr;
    logic [15:0] reg_rdata, rdata, d, in_duty = 0, out_duty = 0;
    logic [11:0] sink = 0;
    logic [10:0] boost = 0;
    logic [2:0] fq = 0, ly = 0, sw = 0, md = 0;
    int miscompares = 0, n_checks = 0, seed = 32'h3D9169E6;
    host_model host_model_i(.reg_addr, .reg_rd, .reg_wr, .sys_clk,
        .reg_rdata, .reg_ack);
    backlight_diag_status_regs backlight_diag_status_regs_i(.sys_clk, .rst,
        .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_ack,
        .input_duty_live(in_duty), .output_duty_live(out_duty),
        .sink_current_dac_code(sink), .boost_voltage_code_field(boost),
        .strap_sample, .dim_freq_strap(fq), .string_layout_strap(ly),
        .switch_frequency_strap(sw), .mode_strap(md), .strap_detect_done);
    function automatic logic [15:0] exp_strap(input logic [2:0] f, l, s, m);
        return {1'b0, f, 1'b1, l, 2'b00, s, m};
    endfunction
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task xfer(input logic wr, input logic [7:0] a);
        host_model_i.access(wr, a, d, ok);
        if (!ok)
        begin
            miscompares++;
            give_verdict;
        end
        if (!wr)
            rdata = d;
    endtask
    task do_reset;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #5;
        rst = 1'b0;
    endtask
    task capture(input logic [2:0] v);
        logic [15:0] w;
        w = exp_strap(v, v + 3'h1, v + 3'h2, v + 3'h3);
        {fq, ly, sw, md} = {v, v + 3'h1, v + 3'h2, v + 3'h3};
        repeat (3) @(posedge sys_clk);
        #5;
        strap_sample = 1'b1;
        @(posedge sys_clk);
        #5;
        strap_sample = 1'b0;
        `CHK("done", 1'b1, strap_detect_done)
        xfer(1'b0, 8'h1E);
        `CHK("strap", w, rdata)
        `CHK("layout", v + 3'h1, rdata[10:8])
        `CHK("switch freq", v + 3'h2, rdata[5:3])
        `CHK("mode", v + 3'h3, rdata[2:0])
        // a second pulse must not recapture
        {fq, ly, sw, md} = ~{fq, ly, sw, md};
        repeat (3) @(posedge sys_clk);
        #5;
        strap_sample = 1'b1;
        xfer(1'b0, 8'h1E);
        strap_sample = 1'b0;
        `CHK("strap held", w, rdata)
    endtask
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        do_reset;
        xfer(1'b0, 8'h1E);
        `CHK("strap reset", 16'h0800, rdata)
        for (int i = 0; i < 40; i++)
        begin
            in_duty = i == 0 ? 16'hFFFF : 16'($random(seed));
            out_duty = i == 0 ? 16'hFFFF : 16'($random(seed));
            sink = i == 0 ? 12'hFFF : 12'($random(seed));
            boost = i == 0 ? 11'h7FF : 11'($random(seed));
            xfer(1'b0, 8'h16);
            `CHK("input duty", in_duty, rdata)
            xfer(1'b0, 8'h18);
            `CHK("output duty", out_duty, rdata)
            xfer(1'b0, 8'h1A);
            `CHK("sink code", {4'h0, sink}, rdata)
            xfer(1'b0, 8'h1C);
            `CHK("boost code", {5'h00, boost}, rdata)
        end
        // live value moves, so a write that loads data shows up
        boost = ~boost;
        xfer(1'b1, 8'h1C);
        `CHK("write ignored", {5'h00, ~boost}, reg_rdata)
        xfer(1'b0, 8'h20);
        `CHK("unmapped", 16'h0000, rdata)
        $display("live register test done");
        for (int v = 0; v < 8; v++)
        begin
            do_reset;
            capture(3'(v));
        end
        $display("strap capture test done");
        give_verdict;
    end
endmodule
bind backlight_diag_status_regs diag_asserts diag_asserts_i(.sys_clk, .rst,
    .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_ack, .input_duty_live,
    .output_duty_live, .sink_current_dac_code, .boost_voltage_code_field,
    .strap_sample, .strap_detect_done);
